// >>> bench/isc_peer.sv
// Bus neighbour model: pull-ups, remote master and byte source
`timescale 1ns/100ps
`default_nettype none
module isc_peer (
    // Device side of the pins
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Wired lines
    output logic scl_line,
    output logic sda_line
);
    logic scl_drv = 1'b0;
    logic sda_drv = 1'b0;
    logic [7:0] tx = 8'h00;
    int cnt = 0;
    // Pull-ups: a released line reads high
    assign scl_line = !(scl_oe || scl_drv);
    assign sda_line = !(sda_oe || sda_drv);
    task automatic arm(input logic [7:0] b);
        tx = b;
        cnt = 8;
        sda_drv = !b[7];
    endtask
    // Data only moves while SCL is low, so no false Start or Stop
    always @(negedge scl_line) begin
        if (cnt != 0) begin
            cnt = cnt - 1;
            tx = tx << 1;
            sda_drv = (cnt != 0) && !tx[7];
        end
    end
    // Start, one byte MSB first, then the acknowledge slot
    task automatic frame(input logic [7:0] b, output logic ack);
        sda_drv = 1'b1;
        #160 scl_drv = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            sda_drv = !b[i];
            #80 scl_drv = 1'b0;
            #80 scl_drv = 1'b1;
        end
        sda_drv = 1'b0;
        #80 scl_drv = 1'b0;
        #40 ack = !sda_line;
        #40 scl_drv = 1'b1;
    endtask
    // Waits out a stretching slave before the Stop edge
    task automatic stop_cond();
        sda_drv = 1'b1;
        #80 scl_drv = 1'b0;
        wait (scl_line);
        #80 sda_drv = 1'b0;
        #160;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the two-wire port sequencer
`timescale 1ns/100ps
`default_nettype none
`include "isc_defines.svh"
module tb;
    typedef struct packed {
        logic [15:0] ctrl;
        logic sda_low;
        logic [7:0] rx;
    } isc_row_type;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, scl_oe, sda_oe, scl, sda, irq;
    logic hresp, scl_out, sda_out, thresh;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic sda_seen, ack;
    int err_count = 0;
    int num_checks = 0;
    // Master sequences in a legal order; bit 12 keeps the clock released
    isc_row_type rows [7] = '{'{16'h1001, 1'b1, 8'h00},
        '{16'h1008, 1'b0, 8'hA5}, '{16'h1010, 1'b1, 8'h00},
        '{16'h1008, 1'b0, 8'h5A}, '{16'h1030, 1'b0, 8'h00},
        '{16'h1002, 1'b1, 8'h00}, '{16'h1004, 1'b1, 8'h00}};
    isc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .serial_clock_line_in(scl),
        .serial_clock_line_out(scl_out), .serial_clock_line_oe(scl_oe),
        .serial_data_line_in(sda), .serial_data_line_out(sda_out),
        .serial_data_line_oe(sda_oe), .bus_threshold_select(thresh),
        .irq(irq));
    isc_peer peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl),
        .sda_line(sda));
    initial forever #4 hclk = ~hclk;
    always @(posedge hclk) if (sda_oe === 1'b1) sda_seen = 1'b1;
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // One single AHB transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic slv(input logic [15:0] c, input logic [9:0] m,
        input logic [7:0] b, input int s, input logic a);
        bus(1'b1, `ISC_OFS_CTRL, {16'h0, c});
        bus(1'b1, `ISC_OFS_MASK, {22'h0, m});
        peer.frame(b, ack);
        peer.stop_cond();
        chk("slave ack", {31'h0, a}, {31'h0, ack});
        bus(1'b0, `ISC_OFS_STAT, 32'h0);
        chk("slave flag", {31'h0, a}, {31'h0, rd[s]});
        bus(1'b1, `ISC_OFS_STAT, 32'hF);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #(60000 * 8);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].ctrl[3]) peer.arm(rows[i].rx);
            sda_seen = 1'b0;
            bus(1'b1, `ISC_OFS_CTRL, {16'h0, rows[i].ctrl});
            rd = 32'h1F;
            for (int n = 0; n < 5000 && (rd[4:0] & rows[i].ctrl[4:0]) != 0;
                n++) bus(1'b0, `ISC_OFS_CTRL, 32'h0);
            chk("seq bit", 32'h0, {27'h0, rd[4:0]});
            chk("sda pull", {31'h0, rows[i].sda_low}, {31'h0, sda_seen});
            bus(1'b0, `ISC_OFS_RXD, 32'h0);
            if (rows[i].ctrl[3]) chk("rx", {24'h0, rows[i].rx}, {24'h0, rd[7:0]});
            bus(1'b0, `ISC_OFS_STAT, 32'h0);
            chk("done", 32'h1, {31'h0, rd[0]});
            bus(1'b1, `ISC_OFS_STAT, 32'hF);
        end
        slv(16'h1000, 10'h000, 8'h54, 1, 1'b1);
        slv(16'h1000, 10'h000, 8'h56, 1, 1'b0);
        slv(16'h1000, 10'h001, 8'h56, 1, 1'b1);
        slv(16'h1000, 10'h000, 8'h00, 2, 1'b0);
        slv(16'h1080, 10'h000, 8'h00, 2, 1'b1);
        bus(1'b1, `ISC_OFS_MASK, 32'h0);
        bus(1'b1, `ISC_OFS_CTRL, 32'h1040);
        peer.frame(8'h54, ack);
        repeat (8) @(posedge hclk);
        chk("scl held", 32'h1, {31'h0, scl_oe});
        bus(1'b0, `ISC_OFS_CTRL, 32'h0);
        chk("release", 32'h0, {31'h0, rd[`ISC_B_REL]});
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `ISC_OFS_IMSK, 32'h2);
        bus(1'b0, `ISC_OFS_STAT, 32'h0);
        chk("irq on", 32'h1, {31'h0, irq});
        bus(1'b1, `ISC_OFS_CTRL, 32'h1040);
        repeat (8) @(posedge hclk);
        chk("scl free", 32'h0, {31'h0, scl_oe});
        peer.stop_cond();
        bus(1'b1, `ISC_OFS_STAT, 32'hF);
        bus(1'b0, `ISC_OFS_STAT, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b1, `ISC_OFS_CTRL, 32'h1100);
        // Output flop follows the write one edge later
        @(posedge hclk);
        chk("threshold", 32'h1, {31'h0, thresh});
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("line out", 32'h0, {30'h0, scl_out, sda_out});
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `ISC_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h1000, rd);
        chk("threshold reset", 32'h0, {31'h0, thresh});
        bus(1'b0, `ISC_OFS_MASK, 32'h0);
        chk("mask reset", 32'h0, rd);
        bus(1'b1, `ISC_OFS_MASK, 32'hFFFFFFFF);
        bus(1'b0, `ISC_OFS_MASK, 32'h0);
        chk("mask", 32'h3FF, rd);
        bus(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h0, rd);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> hw/isc_ahb_slave.sv
// AHB-Lite slave front end: write in data phase, reads with one wait state
`timescale 1ns/100ps
`default_nettype none
module isc_ahb_slave (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Register side
    output isc_pkg::isc_req_type req,
    input wire logic [31:0] rdata
);
    logic ap;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_addr;

    // Only whole words are used, so the size is not decoded
    assign ap = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            wr_pend <= ap && hwrite;
            rd_pend <= ap && !hwrite;
            if (ap) begin
                dp_addr <= haddr[7:0];
            end
            // Wait state lets read data come from a flop
            hreadyout <= !(ap && !hwrite);
            if (rd_pend) begin
                hrdata <= rdata;
            end
            hresp <= 1'b0;
        end
    end

    assign req = '{wr: wr_pend, rd: rd_pend, addr: dp_addr, wdata: hwdata};
endmodule
`default_nettype wire

// >>> hw/isc_defines.svh
// Register map, field positions, reset values and timing of the two-wire port
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH

`define ISC_OFS_CTRL 8'h00
`define ISC_OFS_MASK 8'h04
`define ISC_OFS_OWN 8'h08
`define ISC_OFS_RXD 8'h0C
`define ISC_OFS_STAT 8'h10
`define ISC_OFS_IMSK 8'h14
`define ISC_OFS_FLAG 8'h18

`define ISC_B_START 0
`define ISC_B_ACKSEQ 4
`define ISC_B_ACKVAL 5
`define ISC_B_STRETCH 6
`define ISC_B_GCALL 7
`define ISC_B_THRESH 8
`define ISC_B_REL 12

`define ISC_SEQ_RST 5'h00
`define ISC_MASK_RST 10'h000
`define ISC_OWN_RST 7'h2A
`define ISC_REL_RST 1'b1
`define ISC_LINE_IDLE 1'b1
`define ISC_GC_BYTE 8'h00

`define ISC_CLK_NS 8
`define ISC_QTR_NS 2500
`define ISC_QTR_CYC ((`ISC_QTR_NS + `ISC_CLK_NS - 1) / `ISC_CLK_NS)

`endif

// >>> hw/isc_pkg.sv
// Types shared by the two-wire port modules
`default_nettype none
package isc_pkg;

    typedef enum logic [2:0] {
        isc_m_idle = 3'b000,
        isc_m_start = 3'b001,
        isc_m_rstart = 3'b010,
        isc_m_stop = 3'b011,
        isc_m_recv = 3'b100,
        isc_m_ack = 3'b101
    } isc_mstate_type;

    typedef enum logic [2:0] {
        isc_s_idle = 3'b000,
        isc_s_bits = 3'b001,
        isc_s_ack = 3'b010,
        isc_s_hold = 3'b011,
        isc_s_skip = 3'b100
    } isc_sstate_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } isc_req_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } isc_pins_type;

endpackage
`default_nettype wire

// >>> hw/isc_sync.sv
// Two-flop synchroniser for the serial line inputs
`timescale 1ns/100ps
`default_nettype none
`include "isc_defines.svh"
module isc_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Lines
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta[i] <= `ISC_LINE_IDLE;
                q[i] <= `ISC_LINE_IDLE;
            end else begin
                meta[i] <= d[i];
                q[i] <= meta[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/isc_top.sv
// Two-wire port sequencer: registers, master sequences, slave matching
`timescale 1ns/100ps
`default_nettype none
`include "isc_defines.svh"
module isc_top (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Serial clock line, open drain
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    // Serial data line, open drain
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // Pad control and interrupt
    output logic bus_threshold_select,
    output logic irq
);
    localparam logic [8:0] qtr_last = 9'(`ISC_QTR_CYC - 1);

    isc_pkg::isc_req_type req;
    isc_pkg::isc_pins_type pins;
    isc_pkg::isc_mstate_type mstate;
    isc_pkg::isc_sstate_type sstate;
    logic [31:0] rdata;
    logic [4:0] seq_req;
    logic [4:0] seq_clr;
    logic ack_data_value, clock_stretch_enable, general_call_enable;
    logic clock_release;
    logic [9:0] amask;
    logic [6:0] own;
    logic [3:0] st, imsk, ev;
    logic [7:0] m_rx, m_data, s_sh, s_data;
    logic [1:0] q;
    logic [2:0] bits;
    logic [8:0] qcnt;
    logic owns, m_scl_oe, m_sda_oe, m_wait, adv, mdone;
    logic [3:0] sbits;
    logic s_first, s_rw, s_match, s_gc, byte_end, hold_go;
    logic scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det;
    logic cwr, mwr, owr, swr, iwr;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    isc_ahb_slave u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .req(req),
        .rdata(rdata)
    );

    isc_sync #(.W(2)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({serial_clock_line_in, serial_data_line_in}),
        .q(pins)
    );

    assign cwr = req.wr && req.addr == `ISC_OFS_CTRL;
    assign mwr = req.wr && req.addr == `ISC_OFS_MASK;
    assign owr = req.wr && req.addr == `ISC_OFS_OWN;
    assign swr = req.wr && req.addr == `ISC_OFS_STAT;
    assign iwr = req.wr && req.addr == `ISC_OFS_IMSK;

    // A software write wins over a hardware clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_req <= `ISC_SEQ_RST;
            ack_data_value <= 1'b0;
            clock_stretch_enable <= 1'b0;
            general_call_enable <= 1'b0;
            bus_threshold_select <= 1'b0;
            clock_release <= `ISC_REL_RST;
        end else if (cwr) begin
            seq_req <= req.wdata[`ISC_B_ACKSEQ:`ISC_B_START];
            ack_data_value <= req.wdata[`ISC_B_ACKVAL];
            clock_stretch_enable <= req.wdata[`ISC_B_STRETCH];
            general_call_enable <= req.wdata[`ISC_B_GCALL];
            bus_threshold_select <= req.wdata[`ISC_B_THRESH];
            clock_release <= req.wdata[`ISC_B_REL];
        end else begin
            if (mdone) begin
                seq_req <= seq_req & ~seq_clr;
            end
            if (hold_go) begin
                clock_release <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amask <= `ISC_MASK_RST;
            own <= `ISC_OWN_RST;
            imsk <= 4'h0;
        end else begin
            if (mwr) begin
                amask <= req.wdata[9:0];
            end
            if (owr) begin
                own <= req.wdata[6:0];
            end
            if (iwr) begin
                imsk <= req.wdata[3:0];
            end
        end
    end

    always_comb begin
        case (mstate)
            isc_pkg::isc_m_start: seq_clr = 5'h01;
            isc_pkg::isc_m_rstart: seq_clr = 5'h02;
            isc_pkg::isc_m_stop: seq_clr = 5'h04;
            isc_pkg::isc_m_recv: seq_clr = 5'h08;
            isc_pkg::isc_m_ack: seq_clr = 5'h10;
            default: seq_clr = 5'h00;
        endcase
    end

    // Quarter-bit divider; it stalls while another device holds the clock low
    assign m_wait = !m_scl_oe && !pins.scl;
    assign adv = mstate != isc_pkg::isc_m_idle && !m_wait && qcnt == 9'h000;
    assign mdone = adv && q == 2'd3 &&
        (mstate != isc_pkg::isc_m_recv || bits == 3'd7);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qcnt <= qtr_last;
        end else if (mstate == isc_pkg::isc_m_idle || adv) begin
            qcnt <= qtr_last;
        end else if (!m_wait) begin
            qcnt <= qcnt - 9'h001;
        end
    end

    // Fixed priority pick; only one request is expected at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mstate <= isc_pkg::isc_m_idle;
            q <= 2'd0;
            bits <= 3'd0;
            owns <= 1'b0;
        end else if (mstate == isc_pkg::isc_m_idle) begin
            q <= 2'd0;
            bits <= 3'd0;
            if (seq_req[0]) begin
                mstate <= isc_pkg::isc_m_start;
            end else if (seq_req[1]) begin
                mstate <= isc_pkg::isc_m_rstart;
            end else if (seq_req[2]) begin
                mstate <= isc_pkg::isc_m_stop;
            end else if (seq_req[3]) begin
                mstate <= isc_pkg::isc_m_recv;
            end else if (seq_req[4]) begin
                mstate <= isc_pkg::isc_m_ack;
            end
        end else if (adv) begin
            q <= q + 2'd1;
            if (q == 2'd3) begin
                bits <= bits + 3'd1;
            end
            if (mdone) begin
                mstate <= isc_pkg::isc_m_idle;
                owns <= mstate != isc_pkg::isc_m_stop;
            end
        end
    end

    // Line drive per quarter; the clock is held low between sequences while owns is set, which a Stop clears
    always_comb begin
        m_scl_oe = owns;
        m_sda_oe = 1'b0;
        case (mstate)
            isc_pkg::isc_m_start: begin
                m_scl_oe = q == 2'd3;
                m_sda_oe = q != 2'd0;
            end
            isc_pkg::isc_m_rstart: begin
                m_scl_oe = q == 2'd0 || q == 2'd3;
                m_sda_oe = q[1];
            end
            isc_pkg::isc_m_stop: begin
                m_scl_oe = q == 2'd0;
                m_sda_oe = !q[1];
            end
            isc_pkg::isc_m_recv: begin
                m_scl_oe = q == 2'd0 || q == 2'd3;
            end
            isc_pkg::isc_m_ack: begin
                m_scl_oe = q == 2'd0 || q == 2'd3;
                m_sda_oe = !ack_data_value;
            end
            default: begin
                m_sda_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m_rx <= 8'h00;
            m_data <= 8'h00;
        end else begin
            if (adv && mstate == isc_pkg::isc_m_recv && q == 2'd1) begin
                m_rx <= {m_rx[6:0], pins.sda};
            end
            if (mdone && mstate == isc_pkg::isc_m_recv) begin
                m_data <= m_rx;
            end
        end
    end

    // Slave side works on the synchronised lines only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_q <= `ISC_LINE_IDLE;
            sda_q <= `ISC_LINE_IDLE;
        end else begin
            scl_q <= pins.scl;
            sda_q <= pins.sda;
        end
    end

    assign scl_rise = pins.scl && !scl_q;
    assign scl_fall = !pins.scl && scl_q;
    assign start_det = pins.scl && scl_q && sda_q && !pins.sda;
    assign stop_det = pins.scl && scl_q && !sda_q && pins.sda;
    assign s_match = ((s_sh[7:1] ^ own) & ~amask[6:0]) == 7'h00;
    assign s_gc = general_call_enable && s_sh == `ISC_GC_BYTE;
    assign byte_end = sstate == isc_pkg::isc_s_bits && scl_fall &&
        sbits == 4'd8;
    assign hold_go = sstate == isc_pkg::isc_s_ack && scl_fall && !s_rw &&
        clock_stretch_enable;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sstate <= isc_pkg::isc_s_idle;
            sbits <= 4'd0;
            s_first <= 1'b0;
            s_rw <= 1'b0;
            s_sh <= 8'h00;
        end else if (start_det) begin
            sstate <= isc_pkg::isc_s_bits;
            sbits <= 4'd0;
            s_first <= 1'b1;
            s_rw <= 1'b0;
        end else if (stop_det) begin
            sstate <= isc_pkg::isc_s_idle;
        end else begin
            case (sstate)
                isc_pkg::isc_s_bits: begin
                    if (scl_rise) begin
                        s_sh <= {s_sh[6:0], pins.sda};
                        sbits <= sbits + 4'd1;
                    end
                    if (byte_end) begin
                        if (s_first && !(s_match || s_gc)) begin
                            sstate <= isc_pkg::isc_s_skip;
                        end else begin
                            sstate <= isc_pkg::isc_s_ack;
                            s_rw <= s_first && s_sh[0];
                        end
                    end
                end
                isc_pkg::isc_s_ack: begin
                    if (scl_fall) begin
                        sbits <= 4'd0;
                        s_first <= 1'b0;
                        if (s_rw) begin
                            sstate <= isc_pkg::isc_s_skip;
                        end else if (clock_stretch_enable) begin
                            sstate <= isc_pkg::isc_s_hold;
                        end else begin
                            sstate <= isc_pkg::isc_s_bits;
                        end
                    end
                end
                isc_pkg::isc_s_hold: begin
                    if (clock_release || !clock_stretch_enable) begin
                        sstate <= isc_pkg::isc_s_bits;
                    end
                end
                isc_pkg::isc_s_skip: begin
                    sstate <= isc_pkg::isc_s_skip;
                end
                default: begin
                    sstate <= isc_pkg::isc_s_idle;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_data <= 8'h00;
        end else if (byte_end && !s_first) begin
            s_data <= s_sh;
        end
    end

    assign ev[0] = mdone;
    assign ev[1] = byte_end && s_first && s_match;
    assign ev[2] = byte_end && s_first && s_gc;
    assign ev[3] = byte_end && !s_first;

    // Sticky events; a new event beats a write-one clear
    for (genvar i = 0; i < 4; i++) begin : g_st
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                st[i] <= 1'b0;
            end else begin
                st[i] <= ev[i] | (st[i] & ~(swr & req.wdata[i]));
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            serial_clock_line_oe <= 1'b0;
            serial_data_line_oe <= 1'b0;
            serial_clock_line_out <= 1'b0;
            serial_data_line_out <= 1'b0;
        end else begin
            irq <= |(st & imsk);
            serial_clock_line_oe <= m_scl_oe || sstate == isc_pkg::isc_s_hold;
            serial_data_line_oe <= m_sda_oe || sstate == isc_pkg::isc_s_ack;
            serial_clock_line_out <= 1'b0;
            serial_data_line_out <= 1'b0;
        end
    end

    always_comb begin
        case (req.addr)
            `ISC_OFS_CTRL: rdata = {19'h00000, clock_release, 3'h0,
                bus_threshold_select, general_call_enable,
                clock_stretch_enable, ack_data_value, seq_req};
            `ISC_OFS_MASK: rdata = {22'h000000, amask};
            `ISC_OFS_OWN: rdata = {25'h0000000, own};
            `ISC_OFS_RXD: rdata = {16'h0000, s_data, m_data};
            `ISC_OFS_STAT: rdata = {28'h0000000, st};
            `ISC_OFS_IMSK: rdata = {28'h0000000, imsk};
            `ISC_OFS_FLAG: rdata = {25'h0000000, sstate, mstate, owns};
            default: rdata = 32'h00000000;
        endcase
    end

    property p_gc_disabled;
        (byte_end && s_first && !general_call_enable && !s_match) |=>
            sstate == isc_pkg::isc_s_skip;
    endproperty
    a_gc_disabled: assert property (p_gc_disabled)
        else $error("general call taken while disabled");

    property p_stretch_enable;
        $rose(sstate == isc_pkg::isc_s_hold) |->
            $past(clock_stretch_enable) ##1 (serial_clock_line_oe ||
            !clock_stretch_enable || clock_release);
    endproperty
    a_stretch_enable: assert property (p_stretch_enable)
        else $error("clock stretch without enable");

    property p_ack_level;
        (mstate == isc_pkg::isc_m_ack && q == 2'd1 && !cwr) |=>
            serial_data_line_oe == !$past(ack_data_value);
    endproperty
    a_ack_level: assert property (p_ack_level)
        else $error("acknowledge slot level wrong");

    property p_ack_clear;
        (mdone && mstate == isc_pkg::isc_m_ack && !cwr) |=>
            !seq_req[4] && mstate == isc_pkg::isc_m_idle;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("ack enable not cleared");

    property p_recv_eight;
        (mdone && mstate == isc_pkg::isc_m_recv && !cwr) |->
            bits == 3'd7 ##1 (!seq_req[3] && m_data == $past(m_rx));
    endproperty
    a_recv_eight: assert property (p_recv_eight)
        else $error("receive did not end after eight bits");

    property p_stop_release;
        (mdone && mstate == isc_pkg::isc_m_stop && !cwr) |=> !seq_req[2]
            ##1 (!serial_clock_line_oe && !serial_data_line_oe);
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("stop left a line driven");

    property p_rstart_fall;
        (mstate == isc_pkg::isc_m_rstart && $rose(m_sda_oe)) |->
            !m_scl_oe && q == 2'd2;
    endproperty
    a_rstart_fall: assert property (p_rstart_fall)
        else $error("repeated start data fell with clock low");

    property p_start_done;
        (mdone && mstate == isc_pkg::isc_m_start && !cwr) |=>
            !seq_req[0] && owns ##1 serial_clock_line_oe;
    endproperty
    a_start_done: assert property (p_start_done)
        else $error("start enable not cleared");

    property p_mask_miss;
        (byte_end && s_first && !s_gc &&
            ((s_sh[7:1] ^ own) & ~amask[6:0]) != 7'h00) |=>
            sstate == isc_pkg::isc_s_skip && !st[1];
    endproperty
    a_mask_miss: assert property (p_mask_miss)
        else $error("unmasked address bit mismatch accepted");

    property p_mask_upper;
        (req.rd && req.addr == `ISC_OFS_MASK) |=>
            hrdata[31:10] == 22'h000000;
    endproperty
    a_mask_upper: assert property (p_mask_upper)
        else $error("mask upper bits not zero");
endmodule
`default_nettype wire
